// ==== hw/rxmb_ctrl.sv ====
// receive message buffer state control: commands, search, events, flags
// Function
// R01: one command per control write, executed at once; ignored commands must be rewritten.
// R02: enable trigger enables when enable bit is 0, disables when it is 1.
// R03: disable in claimed, locked_claimed or receiving is silently dropped.
// R04: lock trigger locks when lock bit is 0, unlocks when it is 1.
// R05: lock while receiving is dropped and sets the lock error flag.
// R06: claim fires when filter matches upcoming slot and current cycle.
// R07: slot, window and combined slot-or-segment begin events from protocol starts.
// R08: status-written fires once the status update engine reports completion.
// R09: module transitions beat software transitions on the same buffer.
// R10: outside receiving, module transition then lock/unlock both apply.
// R11: in idle or locked, claim beats a simultaneous disable.
// R12: in receiving, slot-or-segment begin beats a simultaneous lock.
// R13: search starts at static slot, dynamic minislot and network idle starts.
// R14: a search claims at most two buffers: idle to claimed, locked to locked_claimed.
// R15: with both-channel buffers matching, at most one buffer is claimed.
// R16: among matches on one channel only the lowest number is claimed.
// R17: at next slot start claimed and locked_claimed move to reception.
// R18: buffers in reception keep data and status; frame goes to shadow.
// R19: enable/lock bits report state; disabled states are excluded from search.
// R20: segment begin ends reception; locked case discards and flags frame lost.
// R21: status-written returns status_updating buffers to idle.
// R22: software makes a receive buffer by clearing double-buffer and direction bits.
// R23: enable/disable and lock/unlock move between paired states.
`timescale 1ns/1ps
`include "rxmb_cfg.svh"
module rxmb_ctrl #(
    parameter int N  = `RXMB_NUM_BUF,
    parameter int IW = $clog2(N)
) (
    input  wire logic          clk,
    input  wire logic          reset,
    input  wire logic          cmd_write,
    input  wire logic [IW-1:0] cmd_buf_idx,
    input  wire logic          enable_command_trigger,
    input  wire logic          lock_command_trigger,
    input  wire logic          static_slot_start,
    input  wire logic          dyn_slot_start,
    input  wire logic          minislot_start,
    input  wire logic          symbol_window_start,
    input  wire logic          nit_start,
    input  wire logic [N-1:0]  slot_match,
    input  wire logic [N-1:0]  cycle_match,
    input  wire logic [N-1:0]  chan_a_sel,
    input  wire logic [N-1:0]  chan_b_sel,
    input  wire logic [N-1:0]  double_buffer_select,
    input  wire logic [N-1:0]  tx_direction_select,
    input  wire logic [N-1:0]  status_done,
    input  wire logic          lock_error_clear,
    input  wire logic          frame_lost_clear_a,
    input  wire logic          frame_lost_clear_b,
    output logic      [N-1:0]  enable_state_bit,
    output logic      [N-1:0]  lock_state_bit,
    output logic      [N-1:0]  status_update_req,
    output logic      [N-1:0]  rx_shadow_only,
    output logic               lock_error_flag,
    output logic               frame_lost_flag_a,
    output logic               frame_lost_flag_b,
    output logic               slot_begin_event,
    output logic               window_begin_event,
    output logic               slot_or_segment_begin
);
    rxmb_pkg::rxmb_state_e st [N];
    logic [N-1:0] host_enable;
    logic [N-1:0] host_disable;
    logic [N-1:0] host_lock;
    logic [N-1:0] host_unlock;
    logic [N-1:0] claimable;
    logic [N-1:0] eligible;
    logic [N-1:0] grant_both;
    logic [N-1:0] grant_a;
    logic [N-1:0] grant_b;
    logic [N-1:0] claim_d;
    logic [N-1:0] claim_q;
    logic [N-1:0] receiving_v;
    logic [N-1:0] locked_rx_v;
    logic         search_start;
    logic         one_command;

    // a write holding both triggers is not a single command and is dropped
    assign one_command = cmd_write && (enable_command_trigger ^ lock_command_trigger); // [R01]

    // [R13] claims are made one cycle after the search start
    assign search_start = static_slot_start || minislot_start || nit_start;

    for (genvar i = 0; i < N; i++) begin : g_buf
        logic sel;
        assign sel = one_command && cmd_buf_idx == IW'(i);
        assign host_enable[i]  = sel && enable_command_trigger && !enable_state_bit[i]; // [R02]
        assign host_disable[i] = sel && enable_command_trigger && enable_state_bit[i];  // [R02]
        assign host_lock[i]    = sel && lock_command_trigger && !lock_state_bit[i];     // [R04]
        assign host_unlock[i]  = sel && lock_command_trigger && lock_state_bit[i];      // [R04]
        // [R19] [R22] only enabled single-buffered receive buffers take part
        assign claimable[i] = (st[i] == rxmb_pkg::RXMB_IDLE || st[i] == rxmb_pkg::RXMB_LOCKED)
                              && !double_buffer_select[i] && !tx_direction_select[i];
        assign eligible[i]    = claimable[i] && slot_match[i] && cycle_match[i]; // [R06]
        assign receiving_v[i] = st[i] == rxmb_pkg::RXMB_RECEIVING;
        assign locked_rx_v[i] = st[i] == rxmb_pkg::RXMB_LOCKED_RX;

        rxmb_buf_fsm u_fsm (
            .clk            (clk),
            .reset          (reset),
            .host_enable    (host_enable[i]),
            .host_disable   (host_disable[i]),
            .host_lock      (host_lock[i]),
            .host_unlock    (host_unlock[i]),
            .claim          (claim_q[i]),
            .slot_begin     (slot_begin_event),
            .seg_begin      (slot_or_segment_begin),
            .status_written (status_done[i]),  // [R08]
            .state_q        (st[i]),
            .enable_state_q (enable_state_bit[i]),
            .lock_state_q   (lock_state_bit[i]),
            .status_upd_q   (status_update_req[i]),
            .rx_active_q    (rx_shadow_only[i])
        );
    end

    // per channel lowest-number pick
    rxmb_pick_lowest #(.N(N)) u_pick_both (
        .req   (eligible & chan_a_sel & chan_b_sel),
        .grant (grant_both)
    );
    rxmb_pick_lowest #(.N(N)) u_pick_a (
        .req   (eligible & chan_a_sel & ~chan_b_sel),
        .grant (grant_a)
    );
    rxmb_pick_lowest #(.N(N)) u_pick_b (
        .req   (eligible & chan_b_sel & ~chan_a_sel),
        .grant (grant_b)
    );

    // [R14] [R15] [R16] one per channel, or a single one when both channels share it
    assign claim_d = (|grant_both) ? grant_both : (grant_a | grant_b);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            claim_q <= '0;
        end else begin
            claim_q <= search_start ? claim_d : '0;
        end
    end

    // protocol events, registered so claims and slot starts line up
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            slot_begin_event      <= 1'b0;
            window_begin_event    <= 1'b0;
            slot_or_segment_begin <= 1'b0;
        end else begin
            slot_begin_event      <= static_slot_start || dyn_slot_start;         // [R07]
            window_begin_event    <= symbol_window_start || nit_start;            // [R07]
            slot_or_segment_begin <= static_slot_start || dyn_slot_start ||
                                     symbol_window_start || nit_start;           // [R07]
        end
    end

    // sticky error flags: a set in the clear cycle wins
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            lock_error_flag <= 1'b0;
        end else if (|(host_lock & receiving_v)) begin // [R05]
            lock_error_flag <= 1'b1;
        end else if (lock_error_clear) begin
            lock_error_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            frame_lost_flag_a <= 1'b0;
            frame_lost_flag_b <= 1'b0;
        end else begin
            if (slot_or_segment_begin && |(locked_rx_v & chan_a_sel)) begin // [R20]
                frame_lost_flag_a <= 1'b1;
            end else if (frame_lost_clear_a) begin
                frame_lost_flag_a <= 1'b0;
            end
            if (slot_or_segment_begin && |(locked_rx_v & chan_b_sel)) begin // [R20]
                frame_lost_flag_b <= 1'b1;
            end else if (frame_lost_clear_b) begin
                frame_lost_flag_b <= 1'b0;
            end
        end
    end

    // checks on buffer 0 and on the search as a whole
    sequence s_enable_cmd;
        host_enable[0] && st[0] == rxmb_pkg::RXMB_DISABLED;
    endsequence
    sequence s_claim_idle;
        claim_q[0] && st[0] == rxmb_pkg::RXMB_IDLE;
    endsequence
    sequence s_locked_rx_end;
        slot_or_segment_begin && st[0] == rxmb_pkg::RXMB_LOCKED_RX && chan_a_sel[0] &&
            !host_unlock[0];
    endsequence
    sequence s_slot_claimed;
        st[0] == rxmb_pkg::RXMB_CLAIMED && slot_begin_event && !host_lock[0];
    endsequence

    property p_enable;
        @(posedge clk) disable iff (reset)
        s_enable_cmd |=> enable_state_bit[0] && st[0] == rxmb_pkg::RXMB_IDLE;
    endproperty
    a_enable: assert property (p_enable) else $error("enable did not reach idle"); // [R02]

    property p_dis_ignored;
        @(posedge clk) disable iff (reset)
        host_disable[0] && (st[0] == rxmb_pkg::RXMB_CLAIMED ||
            st[0] == rxmb_pkg::RXMB_LOCKED_CLAIMED || st[0] == rxmb_pkg::RXMB_RECEIVING)
        |=> enable_state_bit[0];
    endproperty
    a_dis_ignored: assert property (p_dis_ignored) else $error("disable not dropped"); // [R03]

    property p_lock_err;
        @(posedge clk) disable iff (reset)
        host_lock[0] && st[0] == rxmb_pkg::RXMB_RECEIVING |=> lock_error_flag;
    endproperty
    a_lock_err: assert property (p_lock_err) else $error("lock error flag not set"); // [R05]

    property p_lock_idle;
        @(posedge clk) disable iff (reset)
        host_lock[0] && st[0] == rxmb_pkg::RXMB_IDLE && !claim_q[0]
        |=> st[0] == rxmb_pkg::RXMB_LOCKED && lock_state_bit[0];
    endproperty
    a_lock_idle: assert property (p_lock_idle) else $error("lock did not apply"); // [R04]

    property p_claim_beats_dis;
        @(posedge clk) disable iff (reset)
        s_claim_idle ##0 host_disable[0] |=> st[0] == rxmb_pkg::RXMB_CLAIMED;
    endproperty
    a_claim_beats_dis: assert property (p_claim_beats_dis) else $error("disable beat claim"); // [R11]

    property p_lock_sls;
        @(posedge clk) disable iff (reset)
        st[0] == rxmb_pkg::RXMB_CLAIMED && slot_begin_event && host_lock[0]
        |=> st[0] == rxmb_pkg::RXMB_LOCKED_RX;
    endproperty
    a_lock_sls: assert property (p_lock_sls) else $error("combined transition wrong"); // [R10]

    property p_rx_flow;
        @(posedge clk) disable iff (reset)
        s_slot_claimed |=> st[0] == rxmb_pkg::RXMB_RECEIVING && rx_shadow_only[0];
    endproperty
    a_rx_flow: assert property (p_rx_flow) else $error("claimed buffer not receiving"); // [R17]

    property p_sss_wins;
        @(posedge clk) disable iff (reset)
        st[0] == rxmb_pkg::RXMB_RECEIVING && slot_or_segment_begin
        |=> st[0] == rxmb_pkg::RXMB_STATUS_UPD && status_update_req[0];
    endproperty
    a_sss_wins: assert property (p_sss_wins) else $error("reception not ended"); // [R12]

    property p_frame_lost;
        @(posedge clk) disable iff (reset)
        s_locked_rx_end |=> frame_lost_flag_a && st[0] == rxmb_pkg::RXMB_LOCKED;
    endproperty
    a_frame_lost: assert property (p_frame_lost) else $error("frame lost not flagged"); // [R20]

    property p_su;
        @(posedge clk) disable iff (reset)
        st[0] == rxmb_pkg::RXMB_STATUS_UPD && status_done[0] && !one_command
        |=> st[0] == rxmb_pkg::RXMB_IDLE;
    endproperty
    a_su: assert property (p_su) else $error("status update did not end"); // [R21]

    property p_max_two;
        @(posedge clk) disable iff (reset)
        $countones(claim_q) <= `RXMB_MAX_CLAIMS;
    endproperty
    a_max_two: assert property (p_max_two) else $error("too many claims"); // [R14]

    property p_both_one;
        @(posedge clk) disable iff (reset)
        search_start && |(eligible & chan_a_sel & chan_b_sel)
        |=> $countones(claim_q) == `RXMB_MAX_CLAIMS_2CH;
    endproperty
    a_both_one: assert property (p_both_one) else $error("two-channel claim count"); // [R15]

    property p_lowest;
        @(posedge clk) disable iff (reset)
        search_start && eligible[0] && chan_a_sel[0] && !chan_b_sel[0] && !one_command &&
            st[0] == rxmb_pkg::RXMB_IDLE && !claim_q[0] &&
            !(|(eligible & chan_a_sel & chan_b_sel))
        |=> claim_q[0] && st[0] == rxmb_pkg::RXMB_IDLE ##0
            $countones(claim_q & chan_a_sel & ~chan_b_sel) == 1;
    endproperty
    a_lowest: assert property (p_lowest) else $error("lowest buffer not claimed"); // [R16]

    property p_events;
        @(posedge clk) disable iff (reset)
        (dyn_slot_start || nit_start) |=> slot_or_segment_begin &&
            (slot_begin_event || window_begin_event);
    endproperty
    a_events: assert property (p_events) else $error("begin event missing"); // [R07]

    property p_no_search;
        @(posedge clk) disable iff (reset)
        !search_start |=> claim_q == '0;
    endproperty
    a_no_search: assert property (p_no_search) else $error("claim without search"); // [R13]

    property p_claim_match;
        @(posedge clk) disable iff (reset)
        search_start |=> (claim_q & ~$past(slot_match & cycle_match)) == '0;
    endproperty
    a_claim_match: assert property (p_claim_match) else $error("claim without match"); // [R06]

    // module transitions never touch the host-visible bits
    property p_bits_host;
        @(posedge clk) disable iff (reset)
        !one_command |=> $stable(enable_state_bit) && $stable(lock_state_bit);
    endproperty
    a_bits_host: assert property (p_bits_host) else $error("state bits moved"); // [R19]

    property p_lock_err_src;
        @(posedge clk) disable iff (reset)
        !(|(host_lock & receiving_v)) && !lock_error_flag |=> !lock_error_flag;
    endproperty
    a_lock_err_src: assert property (p_lock_err_src) else $error("spurious lock error"); // [R05]

    property p_fl_a;
        @(posedge clk) disable iff (reset)
        slot_or_segment_begin && |(locked_rx_v & chan_a_sel) |=> frame_lost_flag_a;
    endproperty
    a_fl_a: assert property (p_fl_a) else $error("frame lost a not set"); // [R20]

    property p_fl_b;
        @(posedge clk) disable iff (reset)
        slot_or_segment_begin && |(locked_rx_v & chan_b_sel) |=> frame_lost_flag_b;
    endproperty
    a_fl_b: assert property (p_fl_b) else $error("frame lost b not set"); // [R20]

    property p_slot_ev;
        @(posedge clk) disable iff (reset)
        static_slot_start || dyn_slot_start |=> slot_begin_event && slot_or_segment_begin;
    endproperty
    a_slot_ev: assert property (p_slot_ev) else $error("slot begin missing"); // [R07]

    property p_window_ev;
        @(posedge clk) disable iff (reset)
        symbol_window_start || nit_start |=> window_begin_event && slot_or_segment_begin;
    endproperty
    a_window_ev: assert property (p_window_ev) else $error("window begin missing"); // [R07]

    property p_rx_frozen;
        @(posedge clk) disable iff (reset)
        rx_shadow_only[0] && !slot_or_segment_begin && !host_disable[0] |=> rx_shadow_only[0];
    endproperty
    a_rx_frozen: assert property (p_rx_frozen) else $error("reception left early"); // [R18]

endmodule : rxmb_ctrl

// ==== hw/rxmb_cfg.svh ====
// constants of the receive buffer state control block
`ifndef RXMB_CFG_SVH
`define RXMB_CFG_SVH
`define RXMB_NUM_BUF      8
`define RXMB_MAX_CLAIMS   2
`define RXMB_MAX_CLAIMS_2CH 1
`define RXMB_EDS_RESET    1'b0
`define RXMB_LOCK_STATE_BIT_RESET   1'b0
`endif

// ==== hw/rxmb_pkg.sv ====
// types of the receive buffer state control block
package rxmb_pkg;
    typedef enum logic [3:0] {
        RXMB_DISABLED       = 4'h0,
        RXMB_IDLE           = 4'h1,
        RXMB_LOCKED         = 4'h2,
        RXMB_DIS_LOCKED     = 4'h3,
        RXMB_CLAIMED        = 4'h4,
        RXMB_LOCKED_CLAIMED = 4'h5,
        RXMB_RECEIVING      = 4'h6,
        RXMB_LOCKED_RX      = 4'h7,
        RXMB_STATUS_UPD     = 4'h8
    } rxmb_state_e;
endpackage : rxmb_pkg

// ==== hw/rxmb_pick_lowest.sv ====
// one-hot grant of the lowest set request bit
`timescale 1ns/1ps
module rxmb_pick_lowest #(
    parameter int N = 8
) (
    input  wire logic [N-1:0] req,
    output logic      [N-1:0] grant
);
    always_comb begin
        grant = '0;
        for (int i = N - 1; i >= 0; i--) begin
            if (req[i]) begin
                grant    = '0;
                grant[i] = 1'b1;
            end
        end
    end
endmodule : rxmb_pick_lowest

// ==== hw/rxmb_buf_fsm.sv ====
// state machine of one receive message buffer
`timescale 1ns/1ps
`include "rxmb_cfg.svh"
module rxmb_buf_fsm (
    input  wire logic            clk,
    input  wire logic            reset,
    input  wire logic            host_enable,
    input  wire logic            host_disable,
    input  wire logic            host_lock,
    input  wire logic            host_unlock,
    input  wire logic            claim,
    input  wire logic            slot_begin,
    input  wire logic            seg_begin,
    input  wire logic            status_written,
    output rxmb_pkg::rxmb_state_e state_q,
    output logic                 enable_state_q,
    output logic                 lock_state_q,
    output logic                 status_upd_q,
    output logic                 rx_active_q
);
    rxmb_pkg::rxmb_state_e mod_st;
    rxmb_pkg::rxmb_state_e state_d;

    // module transitions first [R06] [R17] [R20] [R21]
    always_comb begin
        mod_st = state_q;
        case (state_q)
            rxmb_pkg::RXMB_IDLE:           if (claim) mod_st = rxmb_pkg::RXMB_CLAIMED;
            rxmb_pkg::RXMB_LOCKED:         if (claim) mod_st = rxmb_pkg::RXMB_LOCKED_CLAIMED;
            rxmb_pkg::RXMB_CLAIMED:        if (slot_begin) mod_st = rxmb_pkg::RXMB_RECEIVING;
            rxmb_pkg::RXMB_LOCKED_CLAIMED: if (slot_begin) mod_st = rxmb_pkg::RXMB_LOCKED_RX;
            rxmb_pkg::RXMB_RECEIVING:      if (seg_begin) mod_st = rxmb_pkg::RXMB_STATUS_UPD;
            rxmb_pkg::RXMB_LOCKED_RX:      if (seg_begin) mod_st = rxmb_pkg::RXMB_LOCKED;
            rxmb_pkg::RXMB_STATUS_UPD:     if (status_written) mod_st = rxmb_pkg::RXMB_IDLE;
            default:                       mod_st = state_q;
        endcase
    end

    // host command applied to the intermediate state
    always_comb begin
        state_d = mod_st;
        if (host_enable) begin // [R23]
            case (mod_st)
                rxmb_pkg::RXMB_DISABLED:   state_d = rxmb_pkg::RXMB_IDLE;
                rxmb_pkg::RXMB_DIS_LOCKED: state_d = rxmb_pkg::RXMB_LOCKED;
                default:                   state_d = mod_st;
            endcase
        end else if (host_disable && mod_st == state_q) begin // [R11] [R09]
            case (mod_st) // [R03] claimed, locked_claimed, receiving keep state
                rxmb_pkg::RXMB_IDLE:      state_d = rxmb_pkg::RXMB_DISABLED;
                rxmb_pkg::RXMB_LOCKED:    state_d = rxmb_pkg::RXMB_DIS_LOCKED;
                rxmb_pkg::RXMB_LOCKED_RX: state_d = rxmb_pkg::RXMB_DIS_LOCKED;
                default:                  state_d = mod_st;
            endcase
        end else if (host_lock && state_q != rxmb_pkg::RXMB_RECEIVING) begin // [R05] [R12] [R10]
            case (mod_st)
                rxmb_pkg::RXMB_IDLE:      state_d = rxmb_pkg::RXMB_LOCKED;
                rxmb_pkg::RXMB_CLAIMED:   state_d = rxmb_pkg::RXMB_LOCKED_CLAIMED;
                rxmb_pkg::RXMB_RECEIVING: state_d = rxmb_pkg::RXMB_LOCKED_RX;
                rxmb_pkg::RXMB_DISABLED:  state_d = rxmb_pkg::RXMB_DIS_LOCKED;
                default:                  state_d = mod_st;
            endcase
        end else if (host_unlock) begin // [R10] [R23]
            case (mod_st)
                rxmb_pkg::RXMB_LOCKED:         state_d = rxmb_pkg::RXMB_IDLE;
                rxmb_pkg::RXMB_LOCKED_CLAIMED: state_d = rxmb_pkg::RXMB_CLAIMED;
                rxmb_pkg::RXMB_LOCKED_RX:      state_d = rxmb_pkg::RXMB_RECEIVING;
                rxmb_pkg::RXMB_DIS_LOCKED:     state_d = rxmb_pkg::RXMB_DISABLED;
                default:                       state_d = mod_st;
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q        <= rxmb_pkg::RXMB_DISABLED;
            enable_state_q <= `RXMB_EDS_RESET;
            lock_state_q   <= `RXMB_LOCK_STATE_BIT_RESET;
            status_upd_q   <= 1'b0;
            rx_active_q    <= 1'b0;
        end else begin
            state_q        <= state_d;
            // [R19] status bits follow the next state so they never lag it
            enable_state_q <= !(state_d == rxmb_pkg::RXMB_DISABLED ||
                               state_d == rxmb_pkg::RXMB_DIS_LOCKED);
            lock_state_q   <= (state_d == rxmb_pkg::RXMB_LOCKED ||
                               state_d == rxmb_pkg::RXMB_DIS_LOCKED ||
                               state_d == rxmb_pkg::RXMB_LOCKED_CLAIMED ||
                               state_d == rxmb_pkg::RXMB_LOCKED_RX);
            status_upd_q   <= state_d == rxmb_pkg::RXMB_STATUS_UPD;
            // [R18] buffer frozen, frame goes to shadow storage only
            rx_active_q    <= (state_d == rxmb_pkg::RXMB_RECEIVING ||
                               state_d == rxmb_pkg::RXMB_LOCKED_RX);
        end
    end
endmodule : rxmb_buf_fsm

// ==== verif/tb_top.sv ====
// self-checking testbench of the receive buffer state control block
`timescale 1ns/1ps
module tb_top;
    localparam int N = 8;
    localparam logic [3:0] CMDS [8] = '{4'ha, 4'h7, 4'h6, 4'h8, 4'h5, 4'hd, 4'hb, 4'h6};
    logic         clk, reset, cmd_write, en_t, lk_t, le_clr, fa_clr, fb_clr;
    logic         s_st, d_st, m_st, w_st, n_st, lk_err, fl_a, fl_b, sb_ev, wb_ev, ss_ev;
    logic [2:0]   idx;
    logic [N-1:0] sm, cm, ca, cb, dbs, txd, sdone, en_b, lk_b, su_req, rx_sh;
    int           errors;
    int           comparisons;

    rxmb_ctrl #(.N(N), .IW(3)) DUT (
        .clk(clk), .reset(reset), .cmd_write(cmd_write), .cmd_buf_idx(idx),
        .enable_command_trigger(en_t), .lock_command_trigger(lk_t),
        .static_slot_start(s_st), .dyn_slot_start(d_st), .minislot_start(m_st),
        .symbol_window_start(w_st), .nit_start(n_st), .slot_match(sm), .cycle_match(cm),
        .chan_a_sel(ca), .chan_b_sel(cb), .double_buffer_select(dbs),
        .tx_direction_select(txd), .status_done(sdone), .lock_error_clear(le_clr),
        .frame_lost_clear_a(fa_clr), .frame_lost_clear_b(fb_clr),
        .enable_state_bit(en_b), .lock_state_bit(lk_b), .status_update_req(su_req),
        .rx_shadow_only(rx_sh), .lock_error_flag(lk_err), .frame_lost_flag_a(fl_a),
        .frame_lost_flag_b(fl_b), .slot_begin_event(sb_ev), .window_begin_event(wb_ev),
        .slot_or_segment_begin(ss_ev)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            errors++;
            $display("BAD t=%0t %s", $time, msg);
        end
    endtask : chk

    task automatic cmd(input logic [2:0] i, input logic e, input logic l);
        idx = i;
        en_t = e;
        lk_t = l;
        cmd_write = 1'b1;
        tick(1);
        {cmd_write, en_t, lk_t} = 3'h0;
        tick(1);
    endtask : cmd

    // order: static slot, dynamic slot, minislot, symbol window, idle time
    task automatic ev(input logic [4:0] v);
        {s_st, d_st, m_st, w_st, n_st} = v;
        tick(1);
        {s_st, d_st, m_st, w_st, n_st} = 5'h00;
    endtask : ev

    task automatic run_slot(input logic [4:0] srch, input logic [4:0] slot,
                            input logic [N-1:0] exp);
        ev(srch);
        tick(2);
        sm = 8'h00;
        ev(slot);
        chk(sb_ev === 1'b1 && wb_ev === 1'b0 && ss_ev === 1'b1, "slot start events");
        for (int k = 0; k < 4 && rx_sh === 8'h00; k++) tick(1);
        chk(rx_sh === exp, "buffers in reception");
    endtask : run_slot

    task automatic end_rx(input logic [4:0] vec, input logic [N-1:0] exp);
        ev(vec);
        chk(wb_ev === 1'b1 && sb_ev === 1'b0 && ss_ev === 1'b1, "window events");
        for (int k = 0; k < 4 && su_req === 8'h00; k++) tick(1);
        chk(su_req === exp && rx_sh === 8'h00, "status update entered");
        sdone = exp;
        tick(1);
        sdone = 8'h00;
        for (int k = 0; k < 4 && su_req !== 8'h00; k++) tick(1);
        chk(su_req === 8'h00 && (en_b & exp) === exp, "back to idle");
    endtask : end_rx

    task automatic t_reset;
        chk({en_b, lk_b, su_req, rx_sh} === 32'h0000_0000, "reset state");
        chk({lk_err, fl_a, fl_b, sb_ev, wb_ev, ss_ev} === 6'h00, "reset flags");
        $display("test reset done");
    endtask : t_reset

    task automatic t_cmds;
        // trigger pairs walk the enable/lock transitions except disable from locked and unlock from RXMB_DIS_LOCKED, one write dropped
        for (int i = 0; i < 8; i++) begin
            cmd(3'h0, CMDS[i][3], CMDS[i][2]);
            chk(en_b === {7'h00, CMDS[i][1]} && lk_b === {7'h00, CMDS[i][0]}, "cmd");
        end
        $display("test commands done");
    endtask : t_cmds

    task automatic t_rx;
        sm = 8'h01;
        cm = 8'h01;
        ca = 8'h01;
        ev(5'h10);
        cmd(3'h0, 1'b1, 1'b0);
        chk(en_b[0] === 1'b1, "claim beats disable");
        cmd(3'h0, 1'b1, 1'b0);
        chk(en_b[0] === 1'b1, "disable when claimed");
        sm = 8'h00;
        ev(5'h10);
        for (int k = 0; k < 4 && rx_sh[0] !== 1'b1; k++) tick(1);
        chk(rx_sh === 8'h01, "receiving");
        cmd(3'h0, 1'b0, 1'b1);
        tick(1);
        chk(lk_err === 1'b1 && lk_b[0] === 1'b0 && rx_sh[0] === 1'b1, "lock in rx");
        le_clr = 1'b1;
        tick(1);
        le_clr = 1'b0;
        tick(1);
        chk(lk_err === 1'b0, "lock error cleared");
        end_rx(5'h02, 8'h01);
        cmd(3'h0, 1'b1, 1'b0);
        chk(en_b[0] === 1'b0, "disable from idle");
        $display("test reception done");
    endtask : t_rx

    task automatic t_search;
        // 1 double buffered, 3 transmit, 4 disabled: none of them searchable
        dbs = 8'h02;
        txd = 8'h08;
        for (int i = 1; i < 7; i++) if (i != 4) cmd(i[2:0], 1'b1, 1'b0);
        ca = 8'h26;
        cb = 8'h58;
        sm = 8'h7e;
        cm = 8'h7e;
        run_slot(5'h04, 5'h08, 8'h44);
        end_rx(5'h01, 8'h44);
        ca = 8'h64;
        cb = 8'h24;
        sm = 8'h64;
        run_slot(5'h10, 5'h10, 8'h04);
        end_rx(5'h02, 8'h04);
        $display("test search done");
    endtask : t_search

    task automatic t_locked;
        cmd(3'h0, 1'b1, 1'b0);
        cmd(3'h0, 1'b0, 1'b1);
        {ca, cb, sm, cm} = {8'h01, 8'h01, 8'h01, 8'h00};
        ev(5'h10);
        tick(2);
        ev(5'h10);
        tick(3);
        chk(rx_sh === 8'h00, "no claim on cycle miss");
        {sm, cm} = {8'h01, 8'h01};
        run_slot(5'h01, 5'h10, 8'h01);
        ev(5'h02);
        tick(2);
        chk(fl_a === 1'b1 && fl_b === 1'b1 && su_req === 8'h00, "frame lost");
        chk(rx_sh === 8'h00 && en_b[0] === 1'b1 && lk_b[0] === 1'b1, "back to locked");
        {fa_clr, fb_clr} = 2'b11;
        tick(1);
        {fa_clr, fb_clr} = 2'b00;
        tick(1);
        chk({fl_a, fl_b} === 2'b00, "frame lost cleared");
        $display("test locked reception done");
    endtask : t_locked

    task automatic tally_and_finish;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    // whole run is under a hundred cycles, so 5000 cycles means a hang
    initial begin
        #100us;
        errors++;
        tally_and_finish();
    end

    initial begin
        errors = 0;
        comparisons = 0;
        reset = 1'b1;
        idx = 3'h0;
        {cmd_write, en_t, lk_t, s_st, d_st, m_st, w_st, n_st, le_clr, fa_clr, fb_clr} = '0;
        {sm, cm, ca, cb, dbs, txd, sdone} = '0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        t_reset();
        t_cmds();
        t_rx();
        t_search();
        t_locked();
        tally_and_finish();
    end
endmodule : tb_top
